// ==== rtl/grp_hs_io.sv ====
// Function
// - First family: group holding port 0 or 1 uses handshake set one.
// - First family: group of only ports 2 and 3 uses handshake set two.
// - First family: group number never influences handshake set choice.
// - Second family: handshake lines of last listed port are used.
// - Exactly one grouped word moves per completed handshake pulse.
// - Nonbuffered: lines update right after each pulse, no word sequence stored.
// - Nonbuffered accepts 1, 2 or 4 ports; buffered only 2 or 4.
// - Simple buffer: host consumes input words only after the last update or once the buffer is full.
// - Iterative: host may read before the buffer has filled.
// - Circular: position wraps after last entry; runs until stopped.
// - Circular only on the first family.
// - Second family input: load on strobe low, then input-full flag high.
// - Second family output: output-full low with data; acknowledge low pulse back.
// - First family: outside raises request; device drives acknowledge when ready.
`timescale 1ns/1ns
`default_nettype none

module grp_hs_io
  import grp_hs_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
)
(
  input wire logic clk,
  input wire logic srst,
  input wire logic family,
  input wire logic dir,
  input wire logic [1:0] mode,
  input wire logic [3:0] grp_mask,
  input wire logic [1:0] last_port,
  input wire logic [15:0] update_count,
  input wire logic start,
  input wire logic stop,
  output logic busy,
  output logic done,
  output logic cfg_error,
  input wire logic [31:0] dio_in,
  output logic [31:0] dio_out,
  output logic [31:0] dio_oe,
  input wire logic [1:0] req_in,
  output logic [1:0] ack_out,
  input wire logic [3:0] load_strobe_n,
  output logic [3:0] input_full_flag,
  output logic [3:0] output_full_flag_n,
  input wire logic [3:0] ack_n,
  input wire logic [31:0] host_wr_data,
  input wire logic host_wr_valid,
  output logic host_wr_ready,
  output logic [31:0] host_rd_data,
  output logic host_rd_valid,
  input wire logic host_rd_ready
);

  typedef enum logic [1:0] {ST_IDLE, ST_RUN} run_state_e;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [31:0] din_s1_q, din_s2_q;
  logic [1:0] req_s1_q, req_s2_q, req_p_q;
  logic [3:0] ls_s1_q, ls_s2_q, ls_p_q;
  logic [3:0] ack_s1_q, ack_s2_q, ack_p_q;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      din_s1_q <= WORD_RST;
      din_s2_q <= WORD_RST;
      req_s1_q <= SYNC2_RST;
      req_s2_q <= SYNC2_RST;
      req_p_q <= SYNC2_RST;
      ls_s1_q <= SYNC4N_RST;
      ls_s2_q <= SYNC4N_RST;
      ls_p_q <= SYNC4N_RST;
      ack_s1_q <= SYNC4N_RST;
      ack_s2_q <= SYNC4N_RST;
      ack_p_q <= SYNC4N_RST;
    end
    else
    begin
      din_s1_q <= dio_in;
      din_s2_q <= din_s1_q;
      req_s1_q <= req_in;
      req_s2_q <= req_s1_q;
      req_p_q <= req_s2_q;
      ls_s1_q <= load_strobe_n;
      ls_s2_q <= ls_s1_q;
      ls_p_q <= ls_s2_q;
      ack_s1_q <= ack_n;
      ack_s2_q <= ack_s1_q;
      ack_p_q <= ack_s2_q;
    end
  end

  // ----------------------------------------------------------------
  // Active handshake lines
  // ----------------------------------------------------------------
  logic set_sel;
  logic [1:0] port_sel;
  logic cfg_ok;

  hs_line_select i_hs_line_select (
    .family(family),
    .mode(mode),
    .grp_mask(grp_mask),
    .last_port(last_port),
    .update_count(update_count),
    .set_sel(set_sel),
    .port_sel(port_sel),
    .cfg_ok(cfg_ok)
  );

  logic req_rise, ls_fall, ack_fall, hs_event;
  logic [31:0] lanes;

  always_comb
  begin
    lanes = lane_mask(grp_mask);
    req_rise = req_s2_q[set_sel] & ~req_p_q[set_sel];
    // Other strobes are tied by the outside, so only the last port is watched
    ls_fall = ~ls_s2_q[port_sel] & ls_p_q[port_sel];
    ack_fall = ~ack_s2_q[port_sel] & ack_p_q[port_sel];
    if (family == FAM_FIRST)
      hs_event = req_rise;
    else if (dir == DIR_IN)
      hs_event = ls_fall;
    else
      hs_event = ack_fall;
  end

  // ----------------------------------------------------------------
  // Word buffer
  // ----------------------------------------------------------------
  logic [31:0] fifo_in_data, fifo_out_data;
  logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;

  hs_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(DEPTH)
  ) i_hs_fifo (
    .clk(clk),
    .srst(srst),
    .in_data(fifo_in_data),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready)
  );

  // ----------------------------------------------------------------
  // Transfer control
  // ----------------------------------------------------------------
  run_state_e st_q, st_d;
  logic [15:0] cnt_q, cnt_d;
  logic [31:0] hold_q, hold_d;
  logic hold_v_q, hold_v_d;
  logic [31:0] pres_q, pres_d;
  logic pres_v_q, pres_v_d;
  logic done_q, done_d;
  logic err_q, err_d;
  logic running, can_take, take, fetch, finish, last;

  always_comb
  begin
    st_d = st_q;
    cnt_d = cnt_q;
    hold_d = hold_q;
    hold_v_d = hold_v_q;
    pres_d = pres_q;
    pres_v_d = pres_v_q;
    done_d = done_q;
    err_d = err_q;
    running = (st_q == ST_RUN);
    last = (cnt_q == update_count - 16'd1);

    // Input: one capture per event, only when the previous word has left
    can_take = running & (dir == DIR_IN) & ~hold_v_q;
    if (mode == MODE_NONBUF)
      can_take = can_take & ~fifo_out_valid;
    take = can_take & hs_event;

    // Output: word leaves the lines on the completing event
    finish = running & (dir == DIR_OUT) & pres_v_q & hs_event;
    fetch = running & (dir == DIR_OUT) & ~pres_v_q & fifo_out_valid;

    if (fifo_in_valid & fifo_in_ready & (dir == DIR_IN))
      hold_v_d = 1'b0;
    if (take)
    begin
      hold_d = din_s2_q & lanes;
      hold_v_d = 1'b1;
    end
    if (finish)
      pres_v_d = 1'b0;
    if (fetch)
    begin
      pres_d = fifo_out_data & lanes;
      pres_v_d = 1'b1;
    end

    if (take | finish)
    begin
      if (last)
      begin
        cnt_d = CNT_RST;
        if (mode != MODE_CIRC)
        begin
          st_d = ST_IDLE;
          done_d = 1'b1;
        end
      end
      else
        cnt_d = cnt_q + 16'd1;
    end
    if (last & (take | finish) & (mode == MODE_CIRC))
      cnt_d = CNT_RST;

    if (stop)
      st_d = ST_IDLE;
    if (start & (st_q == ST_IDLE))
    begin
      done_d = 1'b0;
      err_d = ~cfg_ok;
      if (cfg_ok)
      begin
        st_d = ST_RUN;
        cnt_d = CNT_RST;
        pres_v_d = 1'b0;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st_q <= ST_IDLE;
      cnt_q <= CNT_RST;
      hold_q <= WORD_RST;
      hold_v_q <= 1'b0;
      pres_q <= WORD_RST;
      pres_v_q <= 1'b0;
      done_q <= 1'b0;
      err_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      hold_q <= hold_d;
      hold_v_q <= hold_v_d;
      pres_q <= pres_d;
      pres_v_q <= pres_v_d;
      done_q <= done_d;
      err_q <= err_d;
    end
  end

  // ----------------------------------------------------------------
  // Buffer steering and host side
  // ----------------------------------------------------------------
  always_comb
  begin
    if (dir == DIR_IN)
    begin
      fifo_in_data = hold_q;
      fifo_in_valid = hold_v_q;
      host_wr_ready = 1'b0;
      // Simple mode holds words back until the run ends or the buffer is full
      host_rd_valid = fifo_out_valid;
      if (mode == MODE_SIMPLE)
        host_rd_valid = fifo_out_valid & (~running | ~fifo_in_ready);
      fifo_out_ready = host_rd_valid & host_rd_ready;
    end
    else
    begin
      fifo_in_data = host_wr_data;
      host_wr_ready = fifo_in_ready;
      if (mode == MODE_NONBUF)
        host_wr_ready = fifo_in_ready & ~fifo_out_valid & ~pres_v_q;
      fifo_in_valid = host_wr_valid & host_wr_ready;
      host_rd_valid = 1'b0;
      fifo_out_ready = fetch;
    end
    host_rd_data = fifo_out_data;
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  always_comb
  begin
    ack_out = 2'h0;
    input_full_flag = 4'h0;
    output_full_flag_n = 4'hf;
    if (family == FAM_FIRST)
    begin
      if (dir == DIR_IN)
        ack_out[set_sel] = can_take;
      else
        ack_out[set_sel] = running & pres_v_q;
    end
    else if (dir == DIR_IN)
      input_full_flag[port_sel] = hold_v_q;
    else
      output_full_flag_n[port_sel] = ~(running & pres_v_q);
    dio_out = pres_q;
    dio_oe = (dir == DIR_OUT) ? lanes : WORD_RST;
    busy = running;
    done = done_q;
    cfg_error = err_q;
  end

endmodule

`default_nettype wire

// ==== rtl/grp_hs_pkg.sv ====
package grp_hs_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int PORTS = 4;
  localparam int PORT_W = 8;
  localparam int WORD_W = 32;
  localparam int FIFO_DEPTH = 16;
  localparam int CNT_W = 16;
  localparam int HS_SETS = 2;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_NONBUF = 2'h0;
  localparam logic [1:0] MODE_SIMPLE = 2'h1;
  localparam logic [1:0] MODE_ITER = 2'h2;
  localparam logic [1:0] MODE_CIRC = 2'h3;
  localparam logic FAM_FIRST = 1'h0;
  localparam logic FAM_SECOND = 1'h1;
  localparam logic DIR_IN = 1'h0;
  localparam logic DIR_OUT = 1'h1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [3:0] SYNC4_RST = 4'h0;
  localparam logic [3:0] SYNC4N_RST = 4'hf;
  localparam logic [1:0] SYNC2_RST = 2'h0;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [2:0] port_count(input logic [3:0] mask);
    port_count = 3'({2'h0, mask[0]} + {2'h0, mask[1]} + {2'h0, mask[2]} + {2'h0, mask[3]});
  endfunction

  function automatic logic [31:0] lane_mask(input logic [3:0] mask);
    lane_mask = {{8{mask[3]}}, {8{mask[2]}}, {8{mask[1]}}, {8{mask[0]}}};
  endfunction

endpackage

// ==== rtl/hs_fifo.sv ====
`timescale 1ns/1ns
`default_nettype none

module hs_fifo
  import grp_hs_pkg::*;
#(
  parameter int WIDTH = WORD_W,
  parameter int DEPTH = FIFO_DEPTH
)
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  // ----------------------------------------------------------------
  // Pointers and occupancy
  // ----------------------------------------------------------------
  always_comb
  begin
    in_ready = (cnt_q != (AW+1)'(DEPTH));
    out_valid = (cnt_q != '0);
    out_data = mem_q[rd_q];
    push = in_valid & in_ready;
    pop = out_valid & out_ready;
    wr_d = push ? ((wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1) : wr_q;
    rd_d = pop ? ((rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1) : rd_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // Storage has no reset
  always_ff @(posedge clk)
  begin
    if (push)
      mem_q[wr_q] <= in_data;
  end

endmodule

`default_nettype wire

// ==== rtl/hs_line_select.sv ====
`timescale 1ns/1ns
`default_nettype none

module hs_line_select
  import grp_hs_pkg::*;
(
  input wire logic family,
  input wire logic [1:0] mode,
  input wire logic [3:0] grp_mask,
  input wire logic [1:0] last_port,
  input wire logic [15:0] update_count,
  output logic set_sel,
  output logic [1:0] port_sel,
  output logic cfg_ok
);

  logic [2:0] n;
  logic size_ok;

  // ----------------------------------------------------------------
  // Active line set and configuration check
  // ----------------------------------------------------------------
  always_comb
  begin
    n = port_count(grp_mask);
    // Only membership decides; no group number input exists
    set_sel = (grp_mask[0] | grp_mask[1]) ? 1'b0 : 1'b1;
    port_sel = last_port;
    if (mode == MODE_NONBUF)
      size_ok = (n == 3'd1) | (n == 3'd2) | (n == 3'd4);
    else
      size_ok = (n == 3'd2) | (n == 3'd4);
    cfg_ok = size_ok & (update_count != CNT_RST);
    if (mode == MODE_CIRC && family != FAM_FIRST)
      cfg_ok = 1'b0;
    if (family == FAM_SECOND && !grp_mask[last_port])
      cfg_ok = 1'b0;
  end

endmodule

`default_nettype wire

// ==== tb/ext_instr.sv ====
`timescale 1ns/1ns
`default_nettype none

module ext_instr
(
  input wire logic clk,
  input wire logic [1:0] ack_out,
  input wire logic [3:0] input_full_flag,
  input wire logic [3:0] output_full_flag_n,
  input wire logic [31:0] dio_out,
  output logic [31:0] dio_in = 32'h0000_0000,
  output logic [1:0] req_in = 2'h0,
  output logic [3:0] load_strobe_n = 4'hf,
  output logic [3:0] ack_n = 4'hf
);
  // Released data lines show the inverse so stale values never match
  task automatic put_req(input int s, input logic [31:0] d, output logic ok);
    ok = 1'b0;
    for (int n = 0; n < 20 && ack_out[s] !== 1'b1; n++)
      @(posedge clk);
    @(negedge clk);
    dio_in = d;
    req_in[s] = 1'b1;
    for (int n = 0; n < 20 && !ok; n++)
    begin
      @(posedge clk);
      ok = (ack_out[s] === 1'b0);
    end
    @(negedge clk);
    req_in[s] = 1'b0;
    dio_in = ~d;
  endtask

  task automatic put_stb(input logic [3:0] g, input logic [1:0] p, input logic [31:0] d, output logic ok);
    ok = 1'b0;
    @(negedge clk);
    dio_in = d;
    load_strobe_n = ~g;
    for (int n = 0; n < 20 && !ok; n++)
    begin
      @(posedge clk);
      ok = (input_full_flag[p] === 1'b1);
    end
    @(negedge clk);
    load_strobe_n = 4'hf;
    dio_in = ~d;
  endtask

  task automatic take_out(input logic [1:0] p, input int lag, output logic [31:0] d, output logic ok);
    ok = 1'b0;
    for (int n = 0; n < 20 && !ok; n++)
    begin
      @(posedge clk);
      ok = (output_full_flag_n[p] === 1'b0);
    end
    d = dio_out;
    repeat (lag + 1) @(negedge clk);
    ack_n[p] = 1'b0;
    repeat (2) @(negedge clk);
    ack_n[p] = 1'b1;
    for (int n = 0; n < 10 && output_full_flag_n[p] !== 1'b1; n++)
      @(posedge clk);
  endtask
endmodule

`default_nettype wire

// ==== tb/grp_hs_io_checker.sv ====
`timescale 1ns/1ns
`default_nettype none

module grp_hs_io_checker
  import grp_hs_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic family,
  input wire logic dir,
  input wire logic [1:0] mode,
  input wire logic [3:0] grp_mask,
  input wire logic [1:0] last_port,
  input wire logic start,
  input wire logic busy,
  input wire logic cfg_error,
  input wire logic [31:0] dio_oe,
  input wire logic [1:0] ack_out,
  input wire logic [3:0] load_strobe_n,
  input wire logic [3:0] input_full_flag,
  input wire logic [3:0] output_full_flag_n,
  input wire logic [3:0] ack_n,
  input wire logic host_rd_valid
);
  logic [3:0] lp1;
  logic [31:0] lanes;
  logic f2;
  assign lp1 = 4'h1 << last_port;
  assign lanes = {{8{grp_mask[3]}}, {8{grp_mask[2]}}, {8{grp_mask[1]}}, {8{grp_mask[0]}}};
  assign f2 = busy && family == FAM_SECOND;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  a_odd_group_refused: assert property (start && !busy && mode != MODE_NONBUF && grp_mask == 4'h1
    |=> cfg_error && !busy) else $error("odd group ran");
  a_circ_second_refused: assert property (start && !busy && mode == MODE_CIRC && family == FAM_SECOND
    |=> cfg_error && !busy) else $error("circular ran");
  a_set_one_only: assert property (busy && family == FAM_FIRST && grp_mask[1:0] != 2'h0
    |-> !ack_out[1]) else $error("set two active");
  a_set_two_only: assert property (busy && family == FAM_FIRST && grp_mask[1:0] == 2'h0
    |-> !ack_out[0]) else $error("set one active");
  a_flag_last_only: assert property ((input_full_flag & ~lp1) == 4'h0) else $error("stray flag");
  a_obf_last_only: assert property ((output_full_flag_n | lp1) == 4'hf) else $error("stray obf");
  a_oe_all_lanes: assert property (dio_oe == (dir == DIR_OUT ? lanes : 32'h0000_0000))
    else $error("bad oe");
  a_strobe_loads: assert property (f2 && dir == DIR_IN && !host_rd_valid && !input_full_flag[last_port]
    && $fell(load_strobe_n[last_port]) |-> ##[2:5] input_full_flag[last_port]) else $error("no load");
  a_ack_frees_obf: assert property (f2 && dir == DIR_OUT && !output_full_flag_n[last_port]
    && $fell(ack_n[last_port]) |-> ##[2:5] output_full_flag_n[last_port]) else $error("obf stuck");
endmodule

bind grp_hs_io grp_hs_io_checker i_grp_hs_io_checker (.clk, .srst, .family, .dir, .mode, .grp_mask,
  .last_port, .start, .busy, .cfg_error, .dio_oe, .ack_out, .load_strobe_n, .input_full_flag,
  .output_full_flag_n, .ack_n, .host_rd_valid);

`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  import grp_hs_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic family = FAM_FIRST;
  logic dir = DIR_IN;
  logic [1:0] mode = MODE_NONBUF;
  logic [3:0] grp_mask = 4'h3;
  logic [1:0] last_port = 2'h0;
  logic [15:0] update_count = 16'h0001;
  logic start = 1'b0;
  logic stop = 1'b0;
  logic [31:0] host_wr_data = 32'h0000_0000;
  logic host_wr_valid = 1'b0;
  logic host_rd_ready = 1'b0;
  logic busy, done, cfg_error, host_wr_ready, host_rd_valid;
  logic [31:0] dio_in, dio_out, dio_oe, host_rd_data;
  logic [1:0] req_in, ack_out;
  logic [3:0] load_strobe_n, input_full_flag, output_full_flag_n, ack_n;
  int n_errors = 0;
  int checks = 0;
  int cyc = 0;

  always #5 clk = ~clk;

  grp_hs_io #(.DEPTH(4)) i_grp_hs_io (.clk, .srst, .family, .dir, .mode, .grp_mask, .last_port,
    .update_count, .start, .stop, .busy, .done, .cfg_error, .dio_in, .dio_out, .dio_oe, .req_in,
    .ack_out, .load_strobe_n, .input_full_flag, .output_full_flag_n, .ack_n, .host_wr_data,
    .host_wr_valid, .host_wr_ready, .host_rd_data, .host_rd_valid, .host_rd_ready);

  ext_instr i_ext_instr (.clk, .ack_out, .input_full_flag, .output_full_flag_n, .dio_out, .dio_in,
    .req_in, .load_strobe_n, .ack_n);

  task automatic report_and_stop();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      n_errors++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] lanes(input logic [3:0] g);
    lanes = {{8{g[3]}}, {8{g[2]}}, {8{g[1]}}, {8{g[0]}}};
  endfunction

  task automatic run(input logic f, input logic d, input logic [1:0] m, input logic [3:0] g,
                     input logic [1:0] lp, input logic [15:0] n);
    @(negedge clk);
    family = f;
    dir = d;
    mode = m;
    grp_mask = g;
    last_port = lp;
    update_count = n;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
  endtask

  task automatic halt();
    @(negedge clk);
    stop = 1'b1;
    @(negedge clk);
    stop = 1'b0;
  endtask

  task automatic rd(input logic [31:0] exp);
    @(negedge clk);
    host_rd_ready = 1'b1;
    for (int n = 0; n < 40; n++)
    begin
      @(posedge clk);
      if (host_rd_valid === 1'b1)
        break;
    end
    chk(host_rd_data, exp);
    @(negedge clk);
    host_rd_ready = 1'b0;
  endtask

  task automatic wr(input logic [31:0] d);
    @(negedge clk);
    host_wr_data = d;
    host_wr_valid = 1'b1;
    for (int n = 0; n < 40; n++)
    begin
      @(posedge clk);
      if (host_wr_ready === 1'b1)
        break;
    end
    @(negedge clk);
    host_wr_valid = 1'b0;
  endtask

  task automatic s_refuse();
    run(FAM_FIRST, DIR_IN, MODE_SIMPLE, 4'h1, 2'h0, 16'h0004);
    chk(32'({busy, cfg_error}), 32'h1);
    run(FAM_FIRST, DIR_IN, MODE_NONBUF, 4'h7, 2'h0, 16'h0004);
    chk(32'({busy, cfg_error}), 32'h1);
    run(FAM_SECOND, DIR_IN, MODE_CIRC, 4'h3, 2'h0, 16'h0004);
    chk(32'({busy, cfg_error}), 32'h1);
    run(FAM_FIRST, DIR_IN, MODE_SIMPLE, 4'h3, 2'h0, 16'h0004);
    chk(32'({busy, cfg_error}), 32'h2);
    halt();
  endtask

  task automatic s_first_in();
    logic [3:0] g [3] = '{4'h3, 4'h2, 4'hc};
    logic ok;
    for (int i = 0; i < 3; i++)
    begin
      run(FAM_FIRST, DIR_IN, MODE_NONBUF, g[i], 2'h0, 16'h0001);
      i_ext_instr.put_req((g[i][1:0] != 2'h0) ? 0 : 1, 32'h5a3c_c3a5 + i, ok);
      chk(32'(ok), 32'h1);
      rd((32'h5a3c_c3a5 + i) & lanes(g[i]));
      chk(32'(done), 32'h1);
    end
  endtask

  task automatic s_second_in();
    logic ok;
    run(FAM_SECOND, DIR_IN, MODE_SIMPLE, 4'hf, 2'h2, 16'h0004);
    for (int i = 0; i < 4; i++)
    begin
      if (i == 3)
        chk(32'(host_rd_valid), 32'h0);
      i_ext_instr.put_stb(4'hf, 2'h2, 32'h1000_0001 << i, ok);
      chk(32'(ok), 32'h1);
    end
    for (int i = 0; i < 4; i++)
      rd(32'h1000_0001 << i);
    chk(32'(done), 32'h1);
  endtask

  task automatic s_second_out();
    logic ok;
    logic [31:0] d;
    run(FAM_SECOND, DIR_OUT, MODE_ITER, 4'h3, 2'h0, 16'h0003);
    chk(dio_oe, 32'h0000_ffff);
    for (int i = 0; i < 3; i++)
      wr(32'h7e81_c300 + i);
    for (int i = 0; i < 3; i++)
    begin
      i_ext_instr.take_out(2'h0, 2 * i, d, ok);
      chk(32'(ok), 32'h1);
      chk(d, 32'h0000_c300 + i);
    end
    chk(32'(done), 32'h1);
  endtask

  task automatic s_first_out();
    logic ok;
    run(FAM_FIRST, DIR_OUT, MODE_NONBUF, 4'hc, 2'h3, 16'h0002);
    for (int i = 0; i < 2; i++)
    begin
      wr(32'h3c5a_a5c3 + i);
      chk(32'(host_wr_ready), 32'h0);
      i_ext_instr.put_req(1, 32'h0000_0000, ok);
      chk(32'(ok), 32'h1);
      chk(dio_out, (32'h3c5a_a5c3 + i) & lanes(4'hc));
    end
    chk(32'(done), 32'h1);
  endtask

  task automatic s_circ();
    logic ok;
    run(FAM_FIRST, DIR_IN, MODE_CIRC, 4'hf, 2'h3, 16'h0002);
    for (int i = 0; i < 3; i++)
    begin
      i_ext_instr.put_req(0, 32'h0bad_f00d ^ i, ok);
      rd(32'h0bad_f00d ^ i);
    end
    chk(32'(busy), 32'h1);
    halt();
    chk(32'({busy, done}), 32'h0);
  endtask

  initial
  begin
    repeat (10) @(posedge clk);
    @(negedge clk);
    srst = 1'b0;
    s_refuse();
    s_first_in();
    s_second_in();
    s_second_out();
    s_first_out();
    s_circ();
    report_and_stop();
  end
endmodule

`default_nettype wire
